/* File: shared/tbusec_consts.svh */
// constants for the translation buffer security and hit-under-miss block
// assumes a 100 MHz system clock and a 32-bit avalon-mm register bus
`ifndef TBUSEC_CONSTS_SVH
`define TBUSEC_CONSTS_SVH

`define TBUSEC_NUM_TBU          32
`define TBUSEC_TBU_ID_W         5
`define TBUSEC_IDX_W_MAX        10
`define TBUSEC_LUT_ADDR_W       15
`define TBUSEC_REGION_SIZE      1024
`define TBUSEC_PROG_MAX         32
`define TBUSEC_WBUF_DEPTH_MAX   16
`define TBUSEC_BEAT_W           5

`define TBUSEC_REG_CTRL         8'h00
`define TBUSEC_REG_STATUS       8'h04
`define TBUSEC_REG_PROG_STATE   8'h08
`define TBUSEC_REG_GFAULT       8'h0c
`define TBUSEC_REG_CFAULT       8'h10
`define TBUSEC_REG_FAULT_CTX    8'h14
`define TBUSEC_REG_AUX          8'h18
`define TBUSEC_REG_SEC_ONLY     8'h1c

`define TBUSEC_CTRL_STALL_MODE  0
`define TBUSEC_CTRL_HIT_UNDER_PRIOR_CONTEXT_FAULT       1
`define TBUSEC_CTRL_GSE         2
`define TBUSEC_CTRL_STALL_DISABLE_BIT      3
`define TBUSEC_CTRL_IRQ_EN      4

`define TBUSEC_CTRL_RESET       32'h0000_0000
`define TBUSEC_AUX_RESET        32'h0000_0000
`define TBUSEC_UNMAPPED_DATA    32'h0000_0000

`endif

/* File: shared/tbusec_pkg.sv */
// types for the translation buffer security and hit-under-miss block
// constants live in tbusec_consts.svh
package tbusec_pkg;

    typedef enum logic [1:0] {
        TBUSEC_IDX_FIXED_NS,
        TBUSEC_IDX_FIXED_S,
        TBUSEC_IDX_PROG_NS,
        TBUSEC_IDX_PROG_S
    } tbusec_idx_kind_e;

    // one address-channel request with its sideband security information
    typedef struct packed {
        logic        valid;
        logic        is_write;
        logic        ns_sideband;
        logic [9:0]  lut_index;
        logic [4:0]  beats;
        logic        tlb_hit;
        logic [3:0]  context_id;
    } tbusec_req_s;

    typedef struct packed {
        logic        valid;
        logic        non_secure;
        logic        pass;
        logic        buffered;
    } tbusec_resp_s;

    typedef enum logic [1:0] {
        TBUSEC_BUS_IDLE,
        TBUSEC_BUS_ANSWER
    } tbusec_bus_e;

endpackage

/* File: src/tbusec_core.sv */
// security determination, write hit-under-miss gating and fault recording
// for one translation buffer unit; registers on avalon-mm with waitrequest;
// the request port comes from logic on the same clock, the override strap
// is a pin.
`timescale 1ns/1ps
`default_nettype none
`include "tbusec_consts.svh"

// Contract
// R1: sideband mode uses per-channel non-secure bit
// R2: table mode looks up per-channel index
// R3: index width parameter zero to ten
// R4: programmable entry count one to thirty-two
// R5: fifteen-bit space, thirty-two 1024-entry regions
// R6: index offsets into own unit region
// R7: valid indices are two to width
// R8: fixed entries ignore software writes
// R9: programmable entries writable, reset to default
// R10: unlisted indices behave fixed non-secure
// R11: index lists must not overlap; not checked, defaults overlap at index 1 (programmable wins)
// R12: at least one non-secure index exists
// R13: override opens aux regs, blocks secure regs
// R14: override forces every transaction non-secure
// R15: read hits always pass read misses
// R16: zero write buffer disables write hum
// R17: write hit passes only if misses fit
// R18: one buffer entry per beat
// R19: full buffer blocks later write hits
// R20: both fault modes, ignore global overrides
// R21: clear hit_under_prior_context_fault spreads fault to context
// R22: faults go global or context status
// R23: override strap sampled once after reset
module tbusec_core #(
    parameter int unsigned  IDX_W      = 6,
    parameter int unsigned  TBU_ID     = 0,
    parameter int unsigned  PROG_N     = 4,
    parameter int unsigned  WBUF_DEPTH = 8,
    parameter logic [31:0]  PROG_DFLT  = 32'h0000_0005,
    parameter logic [1023:0] FIXED_S   = 1024'h2
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic                 sideband_mode_i,
    input  wire logic                 integ_sec_override_i,
    input  wire tbusec_pkg::tbusec_req_s req_i,
    input  wire logic                 miss_done_i,
    input  wire logic [4:0]           miss_done_beats_i,
    input  wire logic                 fault_i,
    input  wire logic                 fault_ctx_valid_i,
    input  wire logic [3:0]           fault_ctx_i,
    input  wire logic [7:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic                 avs_secure_i,
    output logic [31:0]               avs_readdata_o,
    output logic                      avs_waitrequest_o,
    output tbusec_pkg::tbusec_resp_s  resp_o,
    output logic                      stall_o,
    output logic                      irq_o
);

    localparam int unsigned NIDX = 1 << IDX_W;          // [R7]
    localparam logic [14:0] REGION_BASE =
        15'(TBU_ID * `TBUSEC_REGION_SIZE);              // [R5]

    // elaboration-time guards on the configuration
    if (IDX_W > `TBUSEC_IDX_W_MAX) begin : g_bad_w      // [R3]
        $error("lookup index width above ten bits");
    end
    if (PROG_N < 1 || PROG_N > `TBUSEC_PROG_MAX) begin : g_bad_n  // [R4]
        $error("programmable entry count out of range");
    end
    if (WBUF_DEPTH > `TBUSEC_WBUF_DEPTH_MAX) begin : g_bad_d
        $error("write buffer depth too large");
    end

    // programmable entries are indices 0..PROG_N-1 of this unit's region
    function automatic logic [14:0] lut_addr(input logic [9:0] idx);
        lut_addr = REGION_BASE | {5'h00, idx};          // [R6]
    endfunction

    function automatic logic lut_ns(input logic [9:0] idx,
                                    input logic [31:0] prog);
        logic [14:0] a;
        a = lut_addr(idx);
        if ({22'h0, idx} >= NIDX) begin
            lut_ns = 1'b1;
        end else if ({22'h0, idx} < PROG_N) begin
            lut_ns = prog[a[4:0]];                      // [R9]
        end else if (FIXED_S[idx]) begin
            lut_ns = 1'b0;                              // [R8]
        end else begin
            lut_ns = 1'b1;                              // [R10]
        end
    endfunction

    // strap passes three flops, then is frozen once after reset
    logic [2:0] strap_sync_q;
    logic       strap_seen_q;
    logic       override_q;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            strap_sync_q <= 3'h0;
        end else begin
            strap_sync_q <= {strap_sync_q[1:0], integ_sec_override_i};
        end
    end

    // freeze after the sync chain is full; later changes are not followed
    logic [1:0] strap_cnt_q;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            strap_cnt_q  <= 2'h0;
            strap_seen_q <= 1'b0;
            override_q   <= 1'b0;
        end else if (!strap_seen_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == 2'h3 && strap_sync_q[2] == strap_sync_q[1]) begin
                strap_seen_q <= 1'b1;
                override_q   <= strap_sync_q[2];        // [R23]
            end
        end
    end

    // security lookup and hit-under-miss decision
    logic [31:0] prog_state_q;
    logic [4:0]  wbuf_used_q;
    logic        wmiss_pend_q;
    logic        ns_w;
    logic        wfit;
    logic        pass_w;
    logic        ctx_stalled;

    always_comb begin
        if (override_q) begin
            ns_w = 1'b1;                                // [R14]
        end else if (sideband_mode_i) begin
            ns_w = req_i.ns_sideband;                   // [R1]
        end else begin
            ns_w = lut_ns(req_i.lut_index, prog_state_q); // [R2]
        end
    end

    // one entry per beat, so narrow beats still cost a whole entry
    assign wfit = ({1'b0, wbuf_used_q} + {1'b0, req_i.beats})
                  <= 6'(WBUF_DEPTH);                    // [R18]

    always_comb begin
        pass_w = 1'b1;
        if (!req_i.is_write) begin
            pass_w = req_i.tlb_hit || 1'b1;             // [R15]
        end else if (WBUF_DEPTH == 0) begin
            pass_w = !wmiss_pend_q;                     // [R16]
        end else if (req_i.tlb_hit) begin
            pass_w = (wbuf_used_q < 5'(WBUF_DEPTH));    // [R17] [R19]
        end else begin
            pass_w = wfit;                              // [R17]
        end
        if (ctx_stalled) begin
            pass_w = 1'b0;
        end
    end

    logic do_buffer;
    assign do_buffer = req_i.valid && req_i.is_write && !req_i.tlb_hit
                       && pass_w && (WBUF_DEPTH != 0);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wbuf_used_q  <= 5'h00;
            wmiss_pend_q <= 1'b0;
        end else begin
            wbuf_used_q <= wbuf_used_q
                + (do_buffer ? req_i.beats : 5'h00)
                - (miss_done_i ? miss_done_beats_i : 5'h00);   // [R18]
            if (req_i.valid && req_i.is_write && !req_i.tlb_hit && pass_w) begin
                wmiss_pend_q <= 1'b1;
            end else if (miss_done_i) begin
                wmiss_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            resp_o <= '0;
        end else begin
            resp_o.valid      <= req_i.valid;
            resp_o.non_secure <= ns_w;
            resp_o.pass       <= req_i.valid && pass_w;
            resp_o.buffered   <= do_buffer;
        end
    end

    // control, status and fault registers
    logic [31:0] ctrl_q;
    logic [31:0] aux_q;
    logic        gfault_q;
    logic        cfault_q;
    logic [3:0]  fault_ctx_q;
    logic        stall_q;

    // stall or terminate comes from the local bit only
    logic stall_mode;
    assign stall_mode = ctrl_q[`TBUSEC_CTRL_STALL_MODE];  // [R20]

    // with hit_under_prior_context_fault clear, any request in any context is held; with it set, only the faulting context
    assign ctx_stalled = stall_q && req_i.valid
        && (!ctrl_q[`TBUSEC_CTRL_HIT_UNDER_PRIOR_CONTEXT_FAULT]
            || req_i.context_id == fault_ctx_q);        // [R21]

    logic        bus_hit;
    logic        wr_en;
    logic        sec_block;
    tbusec_pkg::tbusec_bus_e bus_st_q;

    // secure-only registers refuse everything while the override is set
    assign sec_block = override_q
        && avs_address_i == `TBUSEC_REG_SEC_ONLY;        // [R13]
    assign bus_hit = (avs_read_i || avs_write_i)
                     && bus_st_q == tbusec_pkg::TBUSEC_BUS_IDLE;
    // a write lands at the edge where the master sees waitrequest low
    assign wr_en = avs_write_i
        && bus_st_q == tbusec_pkg::TBUSEC_BUS_ANSWER && !sec_block
        && (avs_secure_i || override_q
            || avs_address_i != `TBUSEC_REG_AUX);        // [R13]

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bus_st_q <= tbusec_pkg::TBUSEC_BUS_IDLE;
        end else begin
            case (bus_st_q)
                tbusec_pkg::TBUSEC_BUS_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_st_q <= tbusec_pkg::TBUSEC_BUS_ANSWER;
                    end
                end
                default: begin
                    bus_st_q <= tbusec_pkg::TBUSEC_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !bus_hit;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q       <= `TBUSEC_CTRL_RESET;
            aux_q        <= `TBUSEC_AUX_RESET;
            prog_state_q <= PROG_DFLT;                  // [R9]
        end else if (wr_en) begin
            if (avs_address_i == `TBUSEC_REG_CTRL) begin
                ctrl_q <= avs_writedata_i;
            end else if (avs_address_i == `TBUSEC_REG_AUX) begin
                aux_q <= avs_writedata_i;
            end else if (avs_address_i == `TBUSEC_REG_PROG_STATE) begin
                // only bits for programmable entries take the write
                for (int i = 0; i < 32; i++) begin
                    if (i < int'(PROG_N)) begin
                        prog_state_q[i] <= avs_writedata_i[i]; // [R8] [R9]
                    end
                end
            end
        end
    end

    logic clr_g;
    logic clr_c;
    assign clr_g = wr_en && avs_address_i == `TBUSEC_REG_GFAULT
                   && avs_writedata_i[0];
    assign clr_c = wr_en && avs_address_i == `TBUSEC_REG_CFAULT
                   && avs_writedata_i[0];

    // a new fault in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gfault_q    <= 1'b0;
            cfault_q    <= 1'b0;
            fault_ctx_q <= 4'h0;
            stall_q     <= 1'b0;
        end else begin
            if (fault_i && !fault_ctx_valid_i) begin
                gfault_q <= 1'b1;                       // [R22]
            end else if (clr_g) begin
                gfault_q <= 1'b0;
            end
            if (fault_i && fault_ctx_valid_i) begin
                cfault_q    <= 1'b1;                    // [R22]
                fault_ctx_q <= fault_ctx_i;
                stall_q     <= stall_mode;              // [R20]
            end else if (clr_c) begin
                cfault_q <= 1'b0;
                stall_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o   <= 1'b0;
            stall_o <= 1'b0;
        end else begin
            irq_o   <= ctrl_q[`TBUSEC_CTRL_IRQ_EN] && (gfault_q || cfault_q);
            stall_o <= stall_q;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= `TBUSEC_UNMAPPED_DATA;
        end else if (bus_hit && avs_read_i) begin
            if (sec_block) begin
                avs_readdata_o <= `TBUSEC_UNMAPPED_DATA;
            end else if (avs_address_i == `TBUSEC_REG_CTRL) begin
                avs_readdata_o <= ctrl_q;
            end else if (avs_address_i == `TBUSEC_REG_STATUS) begin
                avs_readdata_o <= {24'h0, wmiss_pend_q, override_q,
                                   stall_q, wbuf_used_q};
            end else if (avs_address_i == `TBUSEC_REG_PROG_STATE) begin
                avs_readdata_o <= prog_state_q;
            end else if (avs_address_i == `TBUSEC_REG_GFAULT) begin
                avs_readdata_o <= {31'h0, gfault_q};
            end else if (avs_address_i == `TBUSEC_REG_CFAULT) begin
                avs_readdata_o <= {31'h0, cfault_q};
            end else if (avs_address_i == `TBUSEC_REG_FAULT_CTX) begin
                avs_readdata_o <= {28'h0, fault_ctx_q};
            end else if (avs_address_i == `TBUSEC_REG_AUX) begin
                avs_readdata_o <= aux_q;
            end else begin
                avs_readdata_o <= `TBUSEC_UNMAPPED_DATA;
            end
        end
    end

endmodule
`default_nettype wire

/* File: testbench/tbusec_core_props.sv */
// assertions on the ports of tbusec_core, bound to every instance
// assumes the override strap changes only while reset is held
`timescale 1ns/1ps
`default_nettype none
`include "tbusec_consts.svh"
module tbusec_core_props #(
    parameter int unsigned   IDX_W      = 6,
    parameter int unsigned   PROG_N     = 4,
    parameter int unsigned   WBUF_DEPTH = 8,
    parameter logic [1023:0] FIXED_S    = 1024'h2
) (
    input wire logic                     clk_sys_i,
    input wire logic                     rst_i,
    input wire logic                     sideband_mode_i,
    input wire logic                     integ_sec_override_i,
    input wire tbusec_pkg::tbusec_req_s  req_i,
    input wire logic                     miss_done_i,
    input wire logic [4:0]               miss_done_beats_i,
    input wire logic                     fault_i,
    input wire logic                     fault_ctx_valid_i,
    input wire logic [7:0]               avs_address_i,
    input wire logic                     avs_write_i,
    input wire logic [31:0]              avs_writedata_i,
    input wire logic                     avs_waitrequest_o,
    input wire tbusec_pkg::tbusec_resp_s resp_o,
    input wire logic                     stall_o,
    input wire logic                     irq_o
);
    logic [5:0]  used_q;
    logic [31:0] ctrl_q;
    logic        wmiss, hitw, fits, tbl;
    assign wmiss = req_i.valid && req_i.is_write && !req_i.tlb_hit;
    assign hitw  = req_i.valid && req_i.is_write && req_i.tlb_hit;
    assign fits  = used_q + 6'(req_i.beats) <= 6'(WBUF_DEPTH);
    assign tbl   = req_i.valid && !sideband_mode_i && !integ_sec_override_i;
    // occupancy is predicted at request time so back-to-back writes see it
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            used_q <= 6'h00;
        end else begin
            used_q <= used_q + ((wmiss && fits) ? 6'(req_i.beats) : 6'h00)
                      - (miss_done_i ? 6'(miss_done_beats_i) : 6'h00);
        end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= 32'h0000_0000;
        end else if (avs_write_i && !avs_waitrequest_o
                     && avs_address_i == `TBUSEC_REG_CTRL) begin
            ctrl_q <= avs_writedata_i;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_resp_next: assert property (req_i.valid |=> resp_o.valid)
        else $error("request without response a cycle later");
    a_sideband_ns: assert property (req_i.valid && sideband_mode_i
        && !integ_sec_override_i |=>
        resp_o.non_secure == $past(req_i.ns_sideband))
        else $error("sideband security bit not followed");
    a_override_ns: assert property (req_i.valid && integ_sec_override_i
        |=> resp_o.non_secure)
        else $error("override did not force non-secure");
    a_fixed_secure: assert property (tbl && req_i.lut_index >= PROG_N
        && req_i.lut_index < (1 << IDX_W) && FIXED_S[req_i.lut_index]
        |=> !resp_o.non_secure)
        else $error("fixed secure index answered non-secure");
    a_unlisted_ns: assert property (tbl && req_i.lut_index >= PROG_N
        && (req_i.lut_index >= (1 << IDX_W) || !FIXED_S[req_i.lut_index])
        |=> resp_o.non_secure)
        else $error("unlisted index answered secure");
    a_read_hit: assert property (req_i.valid && !req_i.is_write
        && req_i.tlb_hit && !stall_o |=> resp_o.pass)
        else $error("read hit held back");
    a_miss_buffered: assert property (wmiss |=>
        resp_o.buffered == $past(fits))
        else $error("miss buffering disagrees with free beats");
    a_full_blocks: assert property (hitw && used_q >= 6'(WBUF_DEPTH)
        |=> !resp_o.pass)
        else $error("write hit passed a full buffer");
    a_hit_passes: assert property (hitw && used_q < 6'(WBUF_DEPTH)
        && !stall_o |=> resp_o.pass)
        else $error("write hit held with room left");
    a_stall_fault: assert property (fault_i && fault_ctx_valid_i
        && ctrl_q[`TBUSEC_CTRL_STALL_MODE] |-> ##[1:2] stall_o)
        else $error("stall mode fault did not stall");
    a_term_nostall: assert property (fault_i && !stall_o
        && !ctrl_q[`TBUSEC_CTRL_STALL_MODE] |=> !stall_o [*2])
        else $error("terminate mode fault stalled");
    a_fault_irq: assert property (fault_i && ctrl_q[`TBUSEC_CTRL_IRQ_EN]
        |-> ##[1:2] irq_o)
        else $error("fault raised no interrupt");
endmodule
bind tbusec_core tbusec_core_props #(.IDX_W(IDX_W), .PROG_N(PROG_N),
    .WBUF_DEPTH(WBUF_DEPTH), .FIXED_S(FIXED_S)) u_props (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sideband_mode_i(sideband_mode_i),
    .integ_sec_override_i(integ_sec_override_i), .req_i(req_i),
    .miss_done_i(miss_done_i), .miss_done_beats_i(miss_done_beats_i),
    .fault_i(fault_i), .fault_ctx_valid_i(fault_ctx_valid_i),
    .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
    .resp_o(resp_o), .stall_o(stall_o), .irq_o(irq_o));
`default_nettype wire

/* File: testbench/tbusec_mst_model.sv */
// request master model for tbusec_core plus the miss-drain source
// assumes the bench fills q and dq; one entry leaves per clock
`timescale 1ns/1ps
`default_nettype none
module tbusec_mst_model (
    input  wire logic               clk_sys_i,
    output tbusec_pkg::tbusec_req_s req_o,
    output logic                    miss_done_o,
    output logic [4:0]              miss_done_beats_o
);
    tbusec_pkg::tbusec_req_s q[$];
    logic [4:0]              dq[$];
    tbusec_pkg::tbusec_req_s idle;
    initial begin
        req_o = '0;
        miss_done_o = 1'b0;
        miss_done_beats_o = 5'h00;
    end
    // each request carries its own channel's sideband bit and index
    // idle fields flip every cycle so nothing leans on a stale request
    always @(posedge clk_sys_i) begin
        idle = ~req_o;
        idle.valid = 1'b0;
        req_o <= (q.size() != 0) ? q.pop_front() : idle;
        miss_done_o <= (dq.size() != 0);
        miss_done_beats_o <= (dq.size() != 0) ? dq.pop_front()
                                              : ~miss_done_beats_o;
    end
endmodule
`default_nettype wire

/* File: testbench/tbusec_core_test.sv */
// self-checking bench for tbusec_core: registers, security, write buffer
// assumes the master model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "tbusec_consts.svh"
module tbusec_core_test;
    logic                     clk_sys_i, rst_i, sb, strap, fault, fctx;
    logic                     rd, wr, sec, waitreq, stall, irq, mdone, b;
    logic [7:0]               addr;
    logic [31:0]              wdata, rdata;
    logic [4:0]               mbeats;
    logic [3:0]               e, fcid;
    tbusec_pkg::tbusec_req_s  req;
    tbusec_pkg::tbusec_resp_s resp;
    logic [3:0]               eq[$];
    logic [31:0]              rq[$];
    int                       err_total, n_checks, cyc;
    integer                   seed;
    // index 5 fixed secure, 0..3 programmable, no overlap
    tbusec_core #(.IDX_W(3), .PROG_N(4), .WBUF_DEPTH(8),
        .FIXED_S(1024'h20)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .sideband_mode_i(sb), .integ_sec_override_i(strap), .req_i(req),
        .miss_done_i(mdone), .miss_done_beats_i(mbeats), .fault_i(fault),
        .fault_ctx_valid_i(fctx), .fault_ctx_i(fcid), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_secure_i(sec), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .resp_o(resp), .stall_o(stall),
        .irq_o(irq));
    tbusec_mst_model mst (.clk_sys_i(clk_sys_i), .req_o(req),
        .miss_done_o(mdone), .miss_done_beats_o(mbeats));
    task automatic check(input string nm, input logic [31:0] s, x);
        n_checks++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // a read hands its expected data in d
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        if (!w) rq.push_back(d);
        @(posedge clk_sys_i);
        while (waitreq !== 1'b0) @(posedge clk_sys_i);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // x holds {non_secure, pass, buffered, pass is checked}
    task automatic send(input logic w, hit, ns, input logic [9:0] idx,
                        input logic [4:0] bt, input logic [3:0] x);
        mst.q.push_back('{1'b1, w, ns, idx, bt, hit, 4'h3});
        eq.push_back(x);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        settle(10);
        rst_i <= 1'b0;
        settle(8);
    endtask
    task automatic flt(input logic c);
        @(posedge clk_sys_i);
        fault <= 1'b1;
        fctx <= c;
        fcid <= 4'($random(seed));
        @(posedge clk_sys_i);
        fault <= 1'b0;
        settle(3);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
        if (rd && waitreq === 1'b0) check("rdata", rdata, rq.pop_front());
        if (resp.valid === 1'b1) begin
            e = eq.pop_front();
            check("non_secure", resp.non_secure, e[3]);
            check("buffered", resp.buffered, e[1]);
            if (e[0]) check("pass", resp.pass, e[2]);
        end
    end
    initial begin
        seed = 32'h7449d0c4;
        {rst_i, sb, strap, fault, fctx, rd, wr, sec} = 8'hc1;
        addr = 8'h00;
        fcid = 4'h0;
        wdata = 32'h0000_0000;
        {err_total, n_checks, cyc} = 0;
        do_reset();
        bus(1, `TBUSEC_REG_CTRL, 32'h14);
        bus(0, `TBUSEC_REG_PROG_STATE, 32'h5);
        bus(1, `TBUSEC_REG_PROG_STATE, 32'hffff_fffa);
        bus(0, `TBUSEC_REG_PROG_STATE, 32'ha);
        bus(0, 8'hfc, 32'h0);
        for (int i = 0; i < 8; i++) begin
            b = 1'($random(seed));
            send(0, 1, b, 10'(i), 5'h1, {b, 3'b101});
        end
        settle(12);
        sb <= 1'b0;
        // index 1 and 3 programmed non-secure, 5 fixed secure
        for (int i = 0; i < 10; i++) begin
            send(0, 1, 1'($random(seed)), 10'(i), 5'h1,
                 {10'h3da >> i, 3'b101});
        end
        settle(14);
        send(1, 0, 0, 1, 4, 4'b1010);
        send(1, 0, 0, 1, 3, 4'b1010);
        send(1, 1, 0, 1, 1, 4'b1101);
        send(1, 0, 0, 1, 2, 4'b1000);
        send(1, 0, 0, 1, 1, 4'b1010);
        send(1, 1, 0, 1, 1, 4'b1001);
        send(0, 1, 0, 1, 1, 4'b1101);
        settle(10);
        mst.dq.push_back(5'h4);
        settle(3);
        send(1, 1, 0, 1, 1, 4'b1101);
        settle(4);
        flt(1);
        check("stall", stall, 0);
        check("irq", irq, 1);
        bus(1, `TBUSEC_REG_CFAULT, 32'h1);
        settle(2);
        check("irq", irq, 0);
        bus(1, `TBUSEC_REG_CTRL, 32'h11);
        flt(1);
        check("stall", stall, 1);
        send(0, 1, 0, 1, 1, 4'b1001);
        settle(4);
        bus(1, `TBUSEC_REG_CFAULT, 32'h1);
        settle(2);
        check("stall", stall, 0);
        flt(0);
        check("irq", irq, 1);
        bus(1, `TBUSEC_REG_GFAULT, 32'h1);
        settle(2);
        check("irq", irq, 0);
        strap <= 1'b1;
        do_reset();
        sb <= 1'b1;
        send(0, 1, 0, 1, 1, 4'b1101);
        settle(4);
        sb <= 1'b0;
        send(0, 1, 0, 5, 1, 4'b1101);
        settle(4);
        bus(0, `TBUSEC_REG_SEC_ONLY, 32'h0);
        sec <= 1'b0;
        bus(1, `TBUSEC_REG_AUX, 32'h5a);
        bus(0, `TBUSEC_REG_AUX, 32'h5a);
        check("left", 32'(eq.size()), 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
